// file: mailbox_map.svh
// Register offsets, field positions and reset values of the request mailbox
`ifndef MAILBOX_MAP_SVH
`define MAILBOX_MAP_SVH

// Printed register indices; the byte address is four times the index
`define IDX_REQUEST_COMMAND_CTRL 8'h0e
`define IDX_REQUEST_DATA_WORD_A  8'h0f
`define IDX_REQUEST_DATA_WORD_B  8'h10
`define IDX_IRQ_STATUS           8'h20
`define IDX_IRQ_MASK             8'h21

`define ADDR_REQUEST_COMMAND_CTRL 8'h38
`define ADDR_REQUEST_DATA_WORD_A  8'h3c
`define ADDR_REQUEST_DATA_WORD_B  8'h40
`define ADDR_IRQ_STATUS           8'h80
`define ADDR_IRQ_MASK             8'h84

// Fields of request_command_ctrl
`define CMD_CODE_LSB      0
`define CMD_CODE_MSB      3
`define RESP_IRQ_EN_BIT   4
`define REQ_VALID_BIT     5

// Interrupt status bits
`define IRQ_BIT_POSTED    0
`define IRQ_BIT_CONSUMED  1
`define IRQ_BIT_RESPONSE  2
`define IRQ_COUNT         3

// Reset values
`define RST_COMMAND_CTRL  8'h00
`define RST_DATA_WORD     16'h0000
`define RST_IRQ           3'h0

`endif

// file: mailbox_pkg.sv
// Types shared by the request mailbox design files
package mailbox_pkg;

    typedef enum logic [2:0] {
        SEL_COMMAND,
        SEL_WORD_A,
        SEL_WORD_B,
        SEL_IRQ_STATUS,
        SEL_IRQ_MASK,
        SEL_NONE
    } reg_sel_t;

endpackage : mailbox_pkg

// file: apb_port.sv
// APB slave front end: one setup and one access cycle, registered read data
`timescale 1ns/10ps

module apb_port (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Register side
    output logic [7:0]       reg_addr,
    output logic [31:0]      reg_wdata,
    output logic             reg_wr,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        reg_hit
);

    logic [31:0] rdata_ff;
    logic        err_ff;

    // No wait states: the access phase always completes
    assign pready    = psel & penable;
    assign reg_addr  = paddr;
    assign reg_wdata = pwdata;
    assign reg_wr    = psel & penable & pwrite & reg_hit;
    assign prdata    = rdata_ff;
    assign pslverr   = err_ff;

    // Read data is captured in setup so the access phase sees a flop output
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_ff <= 32'h0000_0000;
            err_ff   <= 1'b0;
        end else if (psel & ~penable) begin
            rdata_ff <= (reg_hit & ~pwrite) ? reg_rdata : 32'h0000_0000;
            err_ff   <= ~reg_hit;
        end
    end

endmodule : apb_port

// file: irq_ctrl.sv
// Sticky interrupt status with write-one-to-clear, mask and level output
`timescale 1ns/10ps
`include "mailbox_map.svh"

module irq_ctrl (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // Events and software controls
    input  wire logic [`IRQ_COUNT-1:0]  event_pulse,
    input  wire logic [`IRQ_COUNT-1:0]  clear_bits,
    input  wire logic [`IRQ_COUNT-1:0]  mask_bits,
    // Status
    output logic [`IRQ_COUNT-1:0]       status,
    output logic                        irq
);

    logic [`IRQ_COUNT-1:0] status_ff;

    genvar i;
    generate
        for (i = 0; i < `IRQ_COUNT; i++) begin : g_bit
            // Set beats clear so an event in the clearing cycle is kept
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    status_ff[i] <= 1'b0;
                end else if (event_pulse[i]) begin
                    status_ff[i] <= 1'b1;
                end else if (clear_bits[i]) begin
                    status_ff[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign status = status_ff;
    assign irq    = |(status_ff & mask_bits);

endmodule : irq_ctrl

// file: inter_core_request_mailbox.sv
// Request mailbox passing commands from the master core to the slave core
// How it works
// - Command register resets to 00h always.
// - Both data words reset to 0000h.
// - Master reads/writes command; slave reads it and writes it only to clear the valid flag.
// - Data words written by master only.
// - Only master can set valid flag.
// - Only slave can clear valid flag.
// - Bit 4 enables response status interrupt.
// - Bits 7:6 read as zero.
// - Each data word holds 16 bits.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
`include "mailbox_map.svh"

module inter_core_request_mailbox (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // APB port of the master core
    input  wire logic        mst_psel,
    input  wire logic        mst_penable,
    input  wire logic        mst_pwrite,
    input  wire logic [7:0]  mst_paddr,
    input  wire logic [31:0] mst_pwdata,
    output logic             mst_pready,
    output logic [31:0]      mst_prdata,
    output logic             mst_pslverr,
    // APB port of the slave core
    input  wire logic        slv_psel,
    input  wire logic        slv_penable,
    input  wire logic        slv_pwrite,
    input  wire logic [7:0]  slv_paddr,
    input  wire logic [31:0] slv_pwdata,
    output logic             slv_pready,
    output logic [31:0]      slv_prdata,
    output logic             slv_pslverr,
    // Slave response logic
    input  wire logic        slave_response_status,
    output logic             response_irq,
    // Mailbox state and interrupt
    output logic             request_valid_flag,
    output logic [3:0]       command_code,
    output logic             irq
);

    logic [7:0]              mst_addr;
    logic [31:0]             mst_wdata;
    logic                    mst_wr;
    logic [31:0]             mst_rdata;
    logic                    mst_hit;
    logic [7:0]              slv_addr;
    logic [31:0]             slv_wdata;
    logic                    slv_wr;
    logic [31:0]             slv_rdata;
    logic                    slv_hit;
    mailbox_pkg::reg_sel_t   mst_sel;
    mailbox_pkg::reg_sel_t   slv_sel;

    logic [3:0]              command_code_ff;
    logic                    response_irq_enable_ff;
    logic                    request_valid_ff;
    logic                    nxt_request_valid;
    logic [15:0]             data_word_a_ff;
    logic [15:0]             data_word_b_ff;
    logic [`IRQ_COUNT-1:0]   irq_mask_ff;
    logic                    response_prev_ff;
    logic                    valid_set;
    logic                    valid_clr;
    logic [`IRQ_COUNT-1:0]   irq_event;
    logic [`IRQ_COUNT-1:0]   irq_clear;
    logic [`IRQ_COUNT-1:0]   irq_status;
    logic [7:0]              command_view;
    logic                    mst_cmd_wr;
    logic                    mst_word_a_wr;
    logic                    mst_word_b_wr;
    logic                    mst_mask_wr;
    logic                    mst_status_wr;
    logic                    slv_cmd_wr;
    logic                    slv_mask_wr;
    logic                    slv_status_wr;
    logic                    req_posted;
    logic                    req_consumed;
    logic                    resp_rose;

    // Field reset values taken from the register's reset byte
    localparam logic [7:0] cmd_reset    = `RST_COMMAND_CTRL;
    localparam logic [3:0] code_reset   = cmd_reset[`CMD_CODE_MSB:`CMD_CODE_LSB];
    localparam logic       irq_en_reset = cmd_reset[`RESP_IRQ_EN_BIT];
    localparam logic       valid_reset  = cmd_reset[`REQ_VALID_BIT];

    // Unaligned or unknown addresses fall to SEL_NONE and are refused
    function automatic mailbox_pkg::reg_sel_t decode(input logic [7:0] addr);
        unique case (addr)
            `ADDR_REQUEST_COMMAND_CTRL: decode = mailbox_pkg::SEL_COMMAND;
            `ADDR_REQUEST_DATA_WORD_A:  decode = mailbox_pkg::SEL_WORD_A;
            `ADDR_REQUEST_DATA_WORD_B:  decode = mailbox_pkg::SEL_WORD_B;
            `ADDR_IRQ_STATUS:           decode = mailbox_pkg::SEL_IRQ_STATUS;
            `ADDR_IRQ_MASK:             decode = mailbox_pkg::SEL_IRQ_MASK;
            default:                    decode = mailbox_pkg::SEL_NONE;
        endcase
    endfunction : decode

    // Unused upper bits read as zero on every register
    function automatic logic [31:0] read_mux(input mailbox_pkg::reg_sel_t sel,
                                             input logic [7:0]  cmd,
                                             input logic [15:0] wa,
                                             input logic [15:0] wb,
                                             input logic [2:0]  st,
                                             input logic [2:0]  mk);
        unique case (sel)
            mailbox_pkg::SEL_COMMAND:    read_mux = {24'h00_0000, cmd};
            mailbox_pkg::SEL_WORD_A:     read_mux = {16'h0000, wa};
            mailbox_pkg::SEL_WORD_B:     read_mux = {16'h0000, wb};
            mailbox_pkg::SEL_IRQ_STATUS: read_mux = {29'h0000_0000, st};
            mailbox_pkg::SEL_IRQ_MASK:   read_mux = {29'h0000_0000, mk};
            mailbox_pkg::SEL_NONE:       read_mux = 32'h0000_0000;
        endcase
    endfunction : read_mux

    // Each core has its own zero-wait-state port
    apb_port u_mst_port (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .psel      (mst_psel),
        .penable   (mst_penable),
        .pwrite    (mst_pwrite),
        .paddr     (mst_paddr),
        .pwdata    (mst_pwdata),
        .pready    (mst_pready),
        .prdata    (mst_prdata),
        .pslverr   (mst_pslverr),
        .reg_addr  (mst_addr),
        .reg_wdata (mst_wdata),
        .reg_wr    (mst_wr),
        .reg_rdata (mst_rdata),
        .reg_hit   (mst_hit)
    );

    apb_port u_slv_port (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .psel      (slv_psel),
        .penable   (slv_penable),
        .pwrite    (slv_pwrite),
        .paddr     (slv_paddr),
        .pwdata    (slv_pwdata),
        .pready    (slv_pready),
        .prdata    (slv_prdata),
        .pslverr   (slv_pslverr),
        .reg_addr  (slv_addr),
        .reg_wdata (slv_wdata),
        .reg_wr    (slv_wr),
        .reg_rdata (slv_rdata),
        .reg_hit   (slv_hit)
    );

    assign mst_sel = decode(mst_addr);
    assign slv_sel = decode(slv_addr);
    assign mst_hit = (mst_sel != mailbox_pkg::SEL_NONE);
    assign slv_hit = (slv_sel != mailbox_pkg::SEL_NONE);

    // Master core write strobes
    assign mst_cmd_wr    = mst_wr && (mst_sel == mailbox_pkg::SEL_COMMAND);
    assign mst_word_a_wr = mst_wr && (mst_sel == mailbox_pkg::SEL_WORD_A);
    assign mst_word_b_wr = mst_wr && (mst_sel == mailbox_pkg::SEL_WORD_B);
    assign mst_mask_wr   = mst_wr && (mst_sel == mailbox_pkg::SEL_IRQ_MASK);
    assign mst_status_wr = mst_wr && (mst_sel == mailbox_pkg::SEL_IRQ_STATUS);

    // Slave core write strobes; the data words have none
    assign slv_cmd_wr    = slv_wr && (slv_sel == mailbox_pkg::SEL_COMMAND);
    assign slv_mask_wr   = slv_wr && (slv_sel == mailbox_pkg::SEL_IRQ_MASK);
    assign slv_status_wr = slv_wr && (slv_sel == mailbox_pkg::SEL_IRQ_STATUS);

    // Reserved bits 7:6 stay zero; each field sits at its own position
    always_comb begin
        command_view                              = 8'h00;
        command_view[`CMD_CODE_MSB:`CMD_CODE_LSB] = command_code_ff;
        command_view[`RESP_IRQ_EN_BIT]            = response_irq_enable_ff;
        command_view[`REQ_VALID_BIT]              = request_valid_ff;
    end

    // Both cores see one view; reads have no side effects
    assign mst_rdata = read_mux(mst_sel, command_view, data_word_a_ff, data_word_b_ff,
                                irq_status, irq_mask_ff);
    assign slv_rdata = read_mux(slv_sel, command_view, data_word_a_ff, data_word_b_ff,
                                irq_status, irq_mask_ff);

    // Command code belongs to the master alone
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            command_code_ff <= code_reset;
        end else if (mst_cmd_wr) begin
            command_code_ff <= mst_wdata[`CMD_CODE_MSB:`CMD_CODE_LSB];
        end
    end

    // The slave reads the enable but has no path to change it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            response_irq_enable_ff <= irq_en_reset;
        end else if (mst_cmd_wr) begin
            response_irq_enable_ff <= mst_wdata[`RESP_IRQ_EN_BIT];
        end
    end

    // Master writes one to post, slave writes zero to acknowledge
    assign valid_set = mst_cmd_wr && mst_wdata[`REQ_VALID_BIT];
    assign valid_clr = slv_cmd_wr && !slv_wdata[`REQ_VALID_BIT];
    // A post racing an acknowledge keeps the flag set, so no request is lost
    assign nxt_request_valid = valid_set | (request_valid_ff & ~valid_clr);

    // Held in a flop so both cores read one settled value
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            request_valid_ff <= valid_reset;
        end else begin
            request_valid_ff <= nxt_request_valid;
        end
    end

    // Slave writes to the data words are dropped; the master is not blocked
    // while the flag is set, so overwriting unread data is its own hazard
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            data_word_a_ff <= `RST_DATA_WORD;
        end else if (mst_word_a_wr) begin
            data_word_a_ff <= mst_wdata[15:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            data_word_b_ff <= `RST_DATA_WORD;
        end else if (mst_word_b_wr) begin
            data_word_b_ff <= mst_wdata[15:0];
        end
    end

    // Interrupt mask is shared; master wins a same-cycle write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_mask_ff <= `RST_IRQ;
        end else if (mst_mask_wr) begin
            irq_mask_ff <= mst_wdata[`IRQ_COUNT-1:0];
        end else if (slv_mask_wr) begin
            irq_mask_ff <= slv_wdata[`IRQ_COUNT-1:0];
        end
    end

    // Previous response status for the rising-edge event
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            response_prev_ff <= 1'b0;
        end else begin
            response_prev_ff <= slave_response_status;
        end
    end

    // Events: flag rising, flag falling, response status rising while enabled
    assign req_posted   = valid_set & ~request_valid_ff;
    assign req_consumed = valid_clr & ~valid_set & request_valid_ff;
    assign resp_rose    = response_irq_enable_ff & slave_response_status
                          & ~response_prev_ff;

    always_comb begin
        irq_event = `RST_IRQ;
        irq_event[`IRQ_BIT_POSTED]   = req_posted;
        irq_event[`IRQ_BIT_CONSUMED] = req_consumed;
        irq_event[`IRQ_BIT_RESPONSE] = resp_rose;
    end

    // Either core clears status bits by writing ones
    always_comb begin
        irq_clear = `RST_IRQ;
        if (mst_status_wr) begin
            irq_clear = irq_clear | mst_wdata[`IRQ_COUNT-1:0];
        end
        if (slv_status_wr) begin
            irq_clear = irq_clear | slv_wdata[`IRQ_COUNT-1:0];
        end
    end

    // Set beats clear inside, so an event during a clearing write stays
    irq_ctrl u_irq (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .event_pulse (irq_event),
        .clear_bits  (irq_clear),
        .mask_bits   (irq_mask_ff),
        .status      (irq_status),
        .irq         (irq)
    );

    // Direct level gating; no extra flop delay on the response path
    assign response_irq       = response_irq_enable_ff & slave_response_status;
    assign request_valid_flag = request_valid_ff;
    assign command_code       = command_code_ff;

endmodule : inter_core_request_mailbox

// file: mailbox_sva.sv
// Concurrent checks on the request mailbox ports
`timescale 1ns/10ps
`include "mailbox_map.svh"

module mailbox_sva (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // Master core port
    input wire logic        mst_psel,
    input wire logic        mst_penable,
    input wire logic        mst_pwrite,
    input wire logic [7:0]  mst_paddr,
    input wire logic [31:0] mst_pwdata,
    input wire logic [31:0] mst_prdata,
    input wire logic        mst_pslverr,
    // Slave core port
    input wire logic        slv_psel,
    input wire logic        slv_penable,
    input wire logic        slv_pwrite,
    input wire logic [7:0]  slv_paddr,
    input wire logic [31:0] slv_pwdata,
    // Mailbox state
    input wire logic        slave_response_status,
    input wire logic        response_irq,
    input wire logic        request_valid_flag,
    input wire logic [3:0]  command_code
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire m_cmd = mst_psel && mst_penable && mst_pwrite && mst_paddr == `ADDR_REQUEST_COMMAND_CTRL;
    wire s_cmd = slv_psel && slv_penable && slv_pwrite && slv_paddr == `ADDR_REQUEST_COMMAND_CTRL;
    sequence s_mrd(a);
        mst_psel && !mst_penable && !mst_pwrite && mst_paddr == a ##1 mst_penable;
    endsequence
    property p_rst; $fell(rst) |-> command_code == 4'h0 && !request_valid_flag; endproperty
    property p_cmd; m_cmd |=> command_code == $past(mst_pwdata[3:0]); endproperty
    property p_set; m_cmd && mst_pwdata[5] |=> request_valid_flag; endproperty
    property p_noset; !request_valid_flag && !m_cmd |=> !request_valid_flag; endproperty
    property p_hold; request_valid_flag && !s_cmd |=> request_valid_flag; endproperty
    property p_clr; s_cmd && !slv_pwdata[5] && !m_cmd |=> !request_valid_flag; endproperty
    property p_ien;
        m_cmd && mst_pwdata[4] |=> (response_irq == slave_response_status)[*2];
    endproperty
    property p_rsv; s_mrd(`ADDR_REQUEST_COMMAND_CTRL) |-> mst_prdata[31:6] == 26'h0; endproperty
    property p_err; s_mrd(8'h44) |-> mst_pslverr && mst_prdata == 32'h0; endproperty
    property p_ro; s_cmd && !m_cmd |=> $stable(command_code); endproperty
    a_rst: assert property (p_rst) else $error("command register not cleared");
    a_cmd: assert property (p_cmd) else $error("command code not written");
    a_set: assert property (p_set) else $error("valid flag not set");
    a_noset: assert property (p_noset) else $error("valid flag set by slave");
    a_hold: assert property (p_hold) else $error("valid flag lost");
    a_clr: assert property (p_clr) else $error("valid flag not cleared");
    a_ien: assert property (p_ien) else $error("response interrupt not gated");
    a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
    a_err: assert property (p_err) else $error("unmapped access not refused");
    a_ro: assert property (p_ro) else $error("slave changed command code");
endmodule : mailbox_sva

bind inter_core_request_mailbox mailbox_sva u_sva (.sys_clk(sys_clk), .rst(rst),
    .mst_psel(mst_psel), .mst_penable(mst_penable), .mst_pwrite(mst_pwrite),
    .mst_paddr(mst_paddr), .mst_pwdata(mst_pwdata), .mst_prdata(mst_prdata),
    .mst_pslverr(mst_pslverr), .slv_psel(slv_psel), .slv_penable(slv_penable),
    .slv_pwrite(slv_pwrite), .slv_paddr(slv_paddr), .slv_pwdata(slv_pwdata),
    .slave_response_status(slave_response_status), .response_irq(response_irq),
    .request_valid_flag(request_valid_flag), .command_code(command_code));

// file: apb_core_model.sv
// Behavioural processor core issuing APB transfers
`timescale 1ns/10ps

module apb_core_model (
    // Clock
    input wire logic         sys_clk,
    // APB request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    // APB answer
    input wire logic         pready,
    input wire logic [31:0]  prdata,
    input wire logic         pslverr,
    // Response status of the slave core
    output logic             resp_valid
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hff;
        pwdata = 32'h0;
        resp_valid = 1'b0;
    end

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e, output bit to);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        to = (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines flip so a stale value cannot pass as still driven
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer

    task automatic set_resp(input logic v);
        @(posedge sys_clk);
        resp_valid <= v;
    endtask : set_resp
endmodule : apb_core_model

// file: testbench.sv
// Self-checking bench of the request mailbox driven by two core models
`timescale 1ns/10ps
`include "mailbox_map.svh"

module testbench;
    logic        sys_clk, rst, slave_response_status, response_irq, request_valid_flag, irq;
    logic        mst_psel, mst_penable, mst_pwrite, mst_pready, mst_pslverr;
    logic        slv_psel, slv_penable, slv_pwrite, slv_pready, slv_pslverr;
    logic [7:0]  mst_paddr, slv_paddr;
    logic [31:0] mst_pwdata, mst_prdata, slv_pwdata, slv_prdata;
    logic [3:0]  command_code;
    int          error_cnt = 0;
    int          check_count = 0;
    localparam logic [7:0] cmd_a = `ADDR_REQUEST_COMMAND_CTRL;
    localparam logic [7:0] wa_a = `ADDR_REQUEST_DATA_WORD_A;
    localparam logic [7:0] wb_a = `ADDR_REQUEST_DATA_WORD_B;
    localparam logic [7:0] st_a = `ADDR_IRQ_STATUS;
    localparam logic [7:0] mk_a = `ADDR_IRQ_MASK;

    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    inter_core_request_mailbox dut (.sys_clk(sys_clk), .rst(rst), .mst_psel(mst_psel),
        .mst_penable(mst_penable), .mst_pwrite(mst_pwrite), .mst_paddr(mst_paddr),
        .mst_pwdata(mst_pwdata), .mst_pready(mst_pready), .mst_prdata(mst_prdata),
        .mst_pslverr(mst_pslverr), .slv_psel(slv_psel), .slv_penable(slv_penable),
        .slv_pwrite(slv_pwrite), .slv_paddr(slv_paddr), .slv_pwdata(slv_pwdata),
        .slv_pready(slv_pready), .slv_prdata(slv_prdata), .slv_pslverr(slv_pslverr),
        .slave_response_status(slave_response_status), .response_irq(response_irq),
        .request_valid_flag(request_valid_flag), .command_code(command_code), .irq(irq));
    apb_core_model u_mst (.sys_clk(sys_clk), .psel(mst_psel), .penable(mst_penable),
        .pwrite(mst_pwrite), .paddr(mst_paddr), .pwdata(mst_pwdata), .pready(mst_pready),
        .prdata(mst_prdata), .pslverr(mst_pslverr), .resp_valid());
    apb_core_model u_slv (.sys_clk(sys_clk), .psel(slv_psel), .penable(slv_penable),
        .pwrite(slv_pwrite), .paddr(slv_paddr), .pwdata(slv_pwdata), .pready(slv_pready),
        .prdata(slv_prdata), .pslverr(slv_pslverr), .resp_valid(slave_response_status));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done;
        if (error_cnt == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done

    // Only 0x44 is used as an unmapped place, so the error bit is expected there alone
    task automatic acc(input bit s, input bit w, input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        bit          to;
        if (s) u_slv.xfer(w, a, w ? d : 32'h0, q, e, to);
        else u_mst.xfer(w, a, w ? d : 32'h0, q, e, to);
        if (to) begin
            error_cnt++;
            test_done();
        end
        chk(32'(e), 32'(a == 8'h44));
        if (!w) chk(q, d);
    endtask : acc

    initial begin
        rst = 1'b1;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        acc(0, 0, cmd_a, 32'h0);
        acc(0, 0, wa_a, 32'h0);
        acc(1, 0, wb_a, 32'h0);
        acc(0, 1, wa_a, 32'h1234a5c3);
        acc(0, 1, wb_a, 32'hffffbeef);
        acc(1, 1, wa_a, 32'h00001111);
        acc(1, 0, wa_a, 32'h0000a5c3);
        acc(0, 0, wb_a, 32'h0000beef);
        acc(0, 1, cmd_a, 32'h000000ef);
        acc(1, 0, cmd_a, 32'h0000002f);
        chk(32'(command_code), 32'hf);
        chk(32'(request_valid_flag), 32'h1);
        acc(1, 1, cmd_a, 32'h0);
        acc(0, 0, cmd_a, 32'h0000000f);
        acc(1, 1, cmd_a, 32'h00000020);
        acc(0, 0, cmd_a, 32'h0000000f);
        acc(0, 1, cmd_a, 32'h0000002a);
        acc(0, 1, cmd_a, 32'h0000000a);
        acc(1, 0, cmd_a, 32'h0000002a);
        acc(0, 0, st_a, 32'h3);
        acc(0, 1, mk_a, 32'h1);
        #1 chk(32'(irq), 32'h1);
        acc(1, 1, st_a, 32'h3);
        #1 chk(32'(irq), 32'h0);
        u_slv.set_resp(1'b1);
        #1 chk(32'(response_irq), 32'h0);
        u_slv.set_resp(1'b0);
        acc(0, 1, cmd_a, 32'h0000003a);
        u_slv.set_resp(1'b1);
        #1 chk(32'(response_irq), 32'h1);
        acc(1, 1, mk_a, 32'h4);
        #1 chk(32'(irq), 32'h1);
        acc(1, 0, st_a, 32'h4);
        acc(0, 1, cmd_a, 32'h0000002a);
        #1 chk(32'(response_irq), 32'h0);
        acc(0, 0, 8'h44, 32'h0);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        acc(0, 0, cmd_a, 32'h0);
        acc(1, 0, wa_a, 32'h0);
        test_done();
    end
endmodule : testbench
